// ===== rtl/mfr_ctrl.sv
// Fault response controller for a three-phase gate driver
//
// What this block does
// - Select one with mask set: temperature faults never disable outputs
// - Select one: supply undervoltage keeps outputs, latches
// - Logic regulator fault: all off, host reset
// - System error: all off, latch, run cleared
// - Select one: bridge fault offs one transistor
// - Demand zero then nonzero re-enables outputs, but a system error needs a run rise
// - Serial read clears supply, sync, bridge and serial error latches unless disabled
// - Sync loss: all off, latch by restart
// - Select zero: supply undervoltage offs all outputs
`timescale 1ns/1ns
module mfr_ctrl
  import mfr_pkg::*;
#(
  parameter int LR_CLEAR_CYC = LR_CLEAR_CYCLES
)
(
  input wire logic clock_i, // System clock, 100 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic enable_i, // Clock enable, freezes state when low
  input wire logic stop_on_fault_select_i, // Fault response select
  input wire logic restart_control_i, // Restart control
  input wire logic logic_reg_undervolt_mask_i, // Lets overtemperature spare outputs in select one
  input wire logic diag_read_clear_disable_i, // Blocks read-clear
  input wire logic run_i, // Run bit level
  input wire logic demand_nonzero_i, // Demand input is nonzero
  input wire logic serial_read_i, // Status or diag read, pulse
  input wire logic serial_error_i, // Serial frame error, pulse
  input wire logic system_error_i, // System error event
  input wire logic main_supply_uv_i, // Main supply undervoltage pin
  input wire logic logic_regulator_uv_i, // Logic regulator uv pin
  input wire logic gate_supply_regulator_uv_i, // Gate regulator uv pin
  input wire logic overtemp_i, // Overtemperature pin
  input wire logic temp_warn_i, // Temperature warning pin
  input wire logic sync_loss_i, // Loss of synchronisation pin
  input wire logic [2:0] bootstrap_uv_i, // Bootstrap uv, high sides
  input wire logic [5:0] drain_source_voltage_ov_i, // Overvoltage pins
  input wire logic [5:0] gate_req_i, // PWM gate demand per transistor
  output logic [5:0] gate_o, // Gate drive outputs
  output logic host_reset_out_n_o, // Host reset, active low
  output logic run_clear_o, // Pulse: clear the run bit
  output logic main_uv_o, // Main supply fault status
  output logic lr_uv_o, // Logic regulator fault status
  output logic sync_loss_o, // Sync loss fault status
  output logic system_error_o, // System error latched
  output logic serial_error_o, // Serial error latched
  output logic temp_warn_o, // Temperature warning status
  output logic overtemp_o, // Overtemperature status
  output logic [5:0] bridge_fault_o, // Per-transistor fault status
  output logic outputs_off_o, // All gates forced off
  output logic restart_wait_o // Waiting for a restart action
);
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] cond;
  logic main_l;
  logic sync_l;
  logic bridge_l;
  logic lr_l;
  logic sys_l;
  logic restart_wait;
  logic [5:0] single_l;
  logic [LR_CNT_W-1:0] lr_cnt;
  logic run_prev;
  logic demand_prev;
  logic [5:0] gate_prev;
  logic stop_on_fault_select;
  logic restart_control;
  logic read_clear;
  logic latch_clear;
  logic run_rise;
  logic demand_rise;
  logic [5:0] bridge_pin;
  logic bridge_any;
  logic rearm_need;
  logic all_off;
  logic next_lr_l;
  logic [LR_CNT_W-1:0] next_lr_cnt;

  function automatic logic rising(input logic cur, input logic prev);
    rising = cur & ~prev;
  endfunction

  assign pins = {drain_source_voltage_ov_i, bootstrap_uv_i, sync_loss_i,
                 temp_warn_i, overtemp_i, gate_supply_regulator_uv_i,
                 logic_regulator_uv_i, main_supply_uv_i};

  mfr_pin_sync #(.W(PIN_N)) u_sync
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(enable_i),
    .pin_i(pins),
    .pin_o(cond)
  );

  assign stop_on_fault_select = stop_on_fault_select_i;
  assign restart_control = restart_control_i;
  assign read_clear = serial_read_i & ~diag_read_clear_disable_i;
  assign latch_clear = ~demand_nonzero_i | ~run_i | read_clear;
  assign run_rise = rising(run_i, run_prev);
  assign demand_rise = rising(demand_nonzero_i, demand_prev);
  assign bridge_pin = cond[POS_VDS +: GATE_N]
                      | {3'h0, cond[POS_BOOT +: HIGH_SIDE_N]};
  assign bridge_any = |bridge_pin;
  // A permitted read clears the latch and the wait in one go
  assign rearm_need = (((main_l & ~stop_on_fault_select) | sync_l | bridge_l) & ~read_clear)
                      | lr_l;

  // Any all-off cause wins over per-transistor disables
  always_comb
  begin
    all_off = sys_l;
    all_off = all_off | cond[POS_GS_UV];
    all_off = all_off | lr_l | cond[POS_LR_UV];
    all_off = all_off | cond[POS_SYNC] | sync_l;
    all_off = all_off | (~stop_on_fault_select & (cond[POS_MAIN_UV] | main_l));
    all_off = all_off | (~stop_on_fault_select & (bridge_any | bridge_l));
    // Overtemperature only spares the outputs in the masked select-one case
    all_off = all_off | (cond[POS_OTEMP]
              & ~(stop_on_fault_select & logic_reg_undervolt_mask_i));
    all_off = all_off | restart_wait;
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      // Follow the inputs so no false edge comes after reset
      run_prev <= run_i;
      demand_prev <= demand_nonzero_i;
      gate_prev <= gate_req_i;
    end
    else if (enable_i)
    begin
      run_prev <= run_i;
      demand_prev <= demand_nonzero_i;
      gate_prev <= gate_req_i;
    end
  end

  // Latched faults: a new set in the clearing cycle wins
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      main_l <= FLAG_RST;
      sync_l <= FLAG_RST;
      bridge_l <= FLAG_RST;
    end
    else if (enable_i)
    begin
      main_l <= (cond[POS_MAIN_UV] & ~restart_control)
                | (main_l & ~latch_clear);
      sync_l <= (cond[POS_SYNC] & ~restart_control) | (sync_l & ~latch_clear);
      bridge_l <= (~stop_on_fault_select & bridge_any) | (bridge_l & ~latch_clear);
    end
  end

  // Per-transistor hold until that transistor's next on-phase
  genvar g;
  generate
    for (g = 0; g < GATE_N; g++)
    begin : gen_single
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
          single_l[g] <= FLAG_RST;
        else if (enable_i)
          single_l[g] <= (stop_on_fault_select & bridge_pin[g])
                         | (single_l[g]
                         & ~rising(gate_req_i[g], gate_prev[g]));
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      sys_l <= FLAG_RST;
      run_clear_o <= FLAG_RST;
    end
    else if (enable_i)
    begin
      sys_l <= system_error_i | (sys_l & ~run_rise);
      run_clear_o <= system_error_i & ~sys_l;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      serial_error_o <= FLAG_RST;
    else if (enable_i)
      serial_error_o <= serial_error_i
                        | (serial_error_o & ~read_clear);
  end

  // Outputs stay off after a latched sync, bridge, regulator or select-zero supply fault until a restart action
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      restart_wait <= FLAG_RST;
    else if (enable_i)
      restart_wait <= rearm_need
                      | (restart_wait
                      & ~(read_clear | run_rise | demand_rise));
  end

  // Regulator recovery timer restarts on every fresh undervoltage
  always_comb
  begin
    next_lr_l = lr_l;
    next_lr_cnt = lr_cnt;
    if (cond[POS_LR_UV])
    begin
      next_lr_l = 1'b1;
      next_lr_cnt = '0;
    end
    else if (lr_l)
    begin
      if (lr_cnt == LR_CNT_W'(LR_CLEAR_CYC - 1))
        next_lr_l = 1'b0;
      else
        next_lr_cnt = lr_cnt + LR_CNT_W'(1);
    end
  end

  // Host held in reset from power-up until the first timer expiry
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      lr_l <= LR_LATCH_RST;
      lr_cnt <= '0;
      host_reset_out_n_o <= HOST_RST_N_RST;
    end
    else if (enable_i)
    begin
      lr_l <= next_lr_l;
      lr_cnt <= next_lr_cnt;
      host_reset_out_n_o <= ~next_lr_l;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      gate_o <= GATE_RST;
      outputs_off_o <= FLAG_RST;
    end
    else if (enable_i)
    begin
      gate_o <= all_off ? GATE_RST : (gate_req_i & ~single_l
                & ~(stop_on_fault_select ? bridge_pin : 6'h00));
      outputs_off_o <= all_off;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      main_uv_o <= FLAG_RST;
      lr_uv_o <= FLAG_RST;
      sync_loss_o <= FLAG_RST;
      system_error_o <= FLAG_RST;
      temp_warn_o <= FLAG_RST;
      overtemp_o <= FLAG_RST;
      bridge_fault_o <= GATE_RST;
      restart_wait_o <= FLAG_RST;
    end
    else if (enable_i)
    begin
      main_uv_o <= cond[POS_MAIN_UV] | main_l;
      lr_uv_o <= cond[POS_LR_UV] | lr_l;
      sync_loss_o <= cond[POS_SYNC] | sync_l;
      system_error_o <= sys_l;
      temp_warn_o <= cond[POS_TWARN];
      overtemp_o <= cond[POS_OTEMP];
      bridge_fault_o <= bridge_pin | single_l | {6{bridge_l}};
      restart_wait_o <= restart_wait;
    end
  end
endmodule

// ===== rtl/mfr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module mfr_pin_sync
  import mfr_pkg::*;
#(
  parameter int W = PIN_N
)
(
  input wire logic clock_i, // System clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic enable_i, // Clock enable
  input wire logic [W-1:0] pin_i, // Asynchronous pin levels
  output logic [W-1:0] pin_o // Filtered synchronous levels
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      stage1 <= W'(PIN_RST);
      stage2 <= W'(PIN_RST);
      stage3 <= W'(PIN_RST);
    end
    else if (enable_i)
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change is taken only when the last two stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : gen_filt
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
          pin_o[g] <= PIN_RST[0];
        else if (enable_i && (stage2[g] == stage3[g]))
          pin_o[g] <= stage3[g];
      end
    end
  endgenerate
endmodule

// ===== rtl/mfr_pkg.sv
// Shared constants for the motor fault response controller
package mfr_pkg;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int LR_CLEAR_TIME_MS = 10;
  localparam int LR_CLEAR_CYCLES = LR_CLEAR_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int LR_CNT_W = $clog2(LR_CLEAR_CYCLES + 1);
  localparam int GATE_N = 6;
  localparam int HIGH_SIDE_N = 3;
  localparam int PIN_N = 15;
  // Bit positions inside the synchronised condition vector
  localparam int POS_MAIN_UV = 0;
  localparam int POS_LR_UV = 1;
  localparam int POS_GS_UV = 2;
  localparam int POS_OTEMP = 3;
  localparam int POS_TWARN = 4;
  localparam int POS_SYNC = 5;
  localparam int POS_BOOT = 6;
  localparam int POS_VDS = 9;
  // Values after reset
  localparam logic [5:0] GATE_RST = 6'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic HOST_RST_N_RST = 1'b0;
  localparam logic LR_LATCH_RST = 1'b1;
  localparam logic [14:0] PIN_RST = 15'h0000;
endpackage

// ===== verif/mfr_ctrl_props.sv
// Port assertions for the fault response controller
`timescale 1ns/1ns
module mfr_ctrl_props
  import mfr_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic stop_on_fault_select_i, // Select
  input wire logic run_i, // Run bit
  input wire logic serial_error_i, // Serial error
  input wire logic system_error_i, // System error
  input wire logic [5:0] gate_o, // Gates
  input wire logic host_reset_out_n_o, // Host reset
  input wire logic run_clear_o, // Run clear
  input wire logic main_uv_o, // Supply status
  input wire logic sync_loss_o, // Sync status
  input wire logic system_error_o, // System flag
  input wire logic serial_error_o, // Serial flag
  input wire logic outputs_off_o // All off
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence clr_pulse_s;
    !system_error_o ##1 (system_error_o && !run_clear_o);
  endsequence
  sys_off_a: assert property (system_error_i |-> ##2 gate_o == 6'h00)
    else $error("gates on after system error");
  run_pulse_a: assert property ($rose(run_clear_o) |-> clr_pulse_s)
    else $error("run clear pulse wrong");
  sys_clr_a:
    assert property ($rose(system_error_o) |-> $past(run_clear_o))
    else $error("no run clear with system error");
  sys_hold_a:
    assert property ($fell(system_error_o) |-> $past(run_i, 2)
      && !$past(run_i, 3))
    else $error("system error cleared without run");
  lr_off_a:
    assert property ((!host_reset_out_n_o) [*2] |-> gate_o == 6'h00)
    else $error("gates on during host reset");
  uv_off_a:
    assert property (main_uv_o && !$past(stop_on_fault_select_i)
      |-> gate_o == 6'h00)
    else $error("gates on during supply fault");
  sync_off_a: assert property (sync_loss_o |-> gate_o == 6'h00)
    else $error("gates on during sync loss");
  err_set_a: assert property (serial_error_i |=> serial_error_o)
    else $error("serial error not flagged");
  all_off_a: assert property (outputs_off_o |-> gate_o == 6'h00)
    else $error("gates on while forced off");
endmodule
bind mfr_ctrl mfr_ctrl_props u_mfr_ctrl_props (.*);

// ===== verif/mfr_host_model.sv
// Host model: run bit, demand level and status reads
`timescale 1ns/1ns
module mfr_host_model
(
  input wire logic clock_i, // Clock
  output logic run_o, // Run bit
  output logic demand_o, // Demand nonzero
  output logic read_o // Read pulse
);
  initial
  begin
    {run_o, demand_o, read_o} = 3'h6;
  end
  task automatic read_status();
    @(posedge clock_i) read_o <= 1'b1;
    @(posedge clock_i) read_o <= 1'b0;
  endtask
  // Zero first, then raise: a bare rise is no restart
  task automatic restart(input bit dem);
    @(posedge clock_i) {run_o, demand_o} <= dem ? 2'h2 : 2'h1;
    @(posedge clock_i) {run_o, demand_o} <= 2'h3;
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the fault response controller
`timescale 1ns/1ns
module tb;
  import mfr_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic enable_i = 1'b1;
  logic gate_supply_regulator_uv_i = 1'b0;
  logic stop_on_fault_select_i, restart_control_i, diag_read_clear_disable_i;
  logic logic_reg_undervolt_mask_i, serial_error_i, system_error_i, run_i;
  logic main_supply_uv_i, logic_regulator_uv_i, overtemp_i, temp_warn_i;
  logic sync_loss_i, demand_nonzero_i, serial_read_i, host_reset_out_n_o;
  logic run_clear_o, main_uv_o, lr_uv_o, sync_loss_o, system_error_o;
  logic serial_error_o, temp_warn_o, overtemp_o, outputs_off_o, restart_wait_o;
  logic [2:0] bootstrap_uv_i;
  logic [5:0] drain_source_voltage_ov_i, gate_o, bridge_fault_o;
  logic [5:0] gate_req_i = 6'h2D;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  mfr_host_model u_mfr_host_model (.clock_i, .run_o(run_i),
    .demand_o(demand_nonzero_i), .read_o(serial_read_i));
  // Short clear time keeps the run brief
  mfr_ctrl #(.LR_CLEAR_CYC(20)) u_mfr_ctrl (.*);
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wt_host();
    int n = 0;
    while (host_reset_out_n_o !== 1'b1 && n < 200)
    begin
      wt(1);
      n++;
    end
    chk(n >= 20, 1'b1);
    wt(2);
  endtask
  task automatic rst();
    @(posedge clock_i);
    resetn_i <= 1'b0;
    {stop_on_fault_select_i, restart_control_i, diag_read_clear_disable_i,
      logic_reg_undervolt_mask_i, serial_error_i, system_error_i} <= '0;
    {main_supply_uv_i, logic_regulator_uv_i, overtemp_i, temp_warn_i,
      sync_loss_i, bootstrap_uv_i, drain_source_voltage_ov_i} <= '0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    wt_host();
    u_mfr_host_model.restart(1'b1);
    wt(2);
    chk(gate_o, gate_req_i);
  endtask
  task automatic t_sys();
    rst();
    @(posedge clock_i) system_error_i <= 1'b1;
    @(posedge clock_i) system_error_i <= 1'b0;
    #1 chk({run_clear_o, system_error_o}, 2'h2);
    wt(2);
    chk({run_clear_o, system_error_o, gate_o}, 8'h40);
    u_mfr_host_model.restart(1'b0);
    wt(3);
    chk({system_error_o, gate_o}, {1'b0, gate_req_i});
    $display("system error done");
  endtask
  task automatic t_lr();
    rst();
    @(posedge clock_i) logic_regulator_uv_i <= 1'b1;
    wt(7);
    chk({host_reset_out_n_o, lr_uv_o, outputs_off_o, gate_o}, 9'h0C0);
    @(posedge clock_i) logic_regulator_uv_i <= 1'b0;
    wt_host();
    chk({restart_wait_o, gate_o}, 7'h40);
    u_mfr_host_model.restart(1'b1);
    wt(3);
    chk(gate_o, gate_req_i);
    $display("regulator done");
  endtask
  task automatic t_uv();
    rst();
    @(posedge clock_i) main_supply_uv_i <= 1'b1;
    wt(7);
    chk({main_uv_o, gate_o}, 7'h40);
    @(posedge clock_i) {main_supply_uv_i, diag_read_clear_disable_i} <= 2'h1;
    serial_error_i <= 1'b1;
    @(posedge clock_i) serial_error_i <= 1'b0;
    wt(7);
    u_mfr_host_model.read_status();
    wt(2);
    chk({serial_error_o, main_uv_o, gate_o}, 8'hC0);
    @(posedge clock_i) diag_read_clear_disable_i <= 1'b0;
    u_mfr_host_model.read_status();
    wt(3);
    chk({serial_error_o, main_uv_o, gate_o}, {2'h0, gate_req_i});
    @(posedge clock_i) {stop_on_fault_select_i, main_supply_uv_i} <= 2'h3;
    wt(7);
    chk({main_uv_o, gate_o}, {1'b1, gate_req_i});
    @(posedge clock_i) main_supply_uv_i <= 1'b0;
    wt(7);
    chk(main_uv_o, 1'b1);
    u_mfr_host_model.restart(1'b1);
    wt(2);
    chk(main_uv_o, 1'b0);
    $display("supply done");
  endtask
  task automatic t_brg();
    rst();
    @(posedge clock_i) {stop_on_fault_select_i, overtemp_i, temp_warn_i} <= '1;
    {logic_reg_undervolt_mask_i, bootstrap_uv_i} <= 4'h9;
    drain_source_voltage_ov_i <= 6'h20;
    wt(7);
    chk({overtemp_o, temp_warn_o, gate_o, bridge_fault_o}, 14'h3321);
    @(posedge clock_i) {overtemp_i, temp_warn_i, bootstrap_uv_i} <= '0;
    drain_source_voltage_ov_i <= 6'h00;
    wt(7);
    chk({overtemp_o, temp_warn_o, gate_o}, 8'h0C);
    @(posedge clock_i) gate_req_i <= 6'h0C;
    @(posedge clock_i) gate_req_i <= 6'h2D;
    wt(3);
    chk(gate_o, 6'h2D);
    $display("bridge done");
  endtask
  task automatic t_sync();
    rst();
    @(posedge clock_i) {stop_on_fault_select_i, restart_control_i} <= 2'h3;
    {sync_loss_i, drain_source_voltage_ov_i} <= 7'h41;
    wt(7);
    chk({sync_loss_o, gate_o}, 7'h40);
    @(posedge clock_i) sync_loss_i <= 1'b0;
    wt(7);
    chk({sync_loss_o, gate_o}, 7'h2C);
    @(posedge clock_i) {restart_control_i, sync_loss_i} <= 2'h1;
    drain_source_voltage_ov_i <= 6'h00;
    // Pin must stand two cycles to pass the filter
    repeat (2) @(posedge clock_i);
    @(posedge clock_i) sync_loss_i <= 1'b0;
    wt(10);
    chk({sync_loss_o, gate_o}, 7'h40);
    u_mfr_host_model.restart(1'b0);
    wt(3);
    chk({sync_loss_o, gate_o}, 7'h2C);
    $display("sync done");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    t_sys();
    t_lr();
    t_uv();
    t_brg();
    t_sync();
    end_sim();
  end
endmodule
